// ===== rss_alu.sv
// execution datapath for rotate, subtract, skip, set and swap instructions
//
// Summary of operation
// - rotate left through carry into accumulator
// - rotate right memory, bit 0 into 7
// - rotate right into accumulator, flags untouched
// - rotate right through carry, carry only
// - subtract with inverted carry as borrow
// - plain subtract, no carry input
// - carry set unless result negative
// - subtracts update all six arithmetic flags
// - decrement memory, skip when zero
// - decrement into accumulator, skip when zero
// - increment memory, skip when zero
// - increment into accumulator, skip when zero
// - taken skip adds one dummy cycle
// - skip when selected memory bit set
// - write byte back, skip if nonzero
// - write byte back, skip if zero
// - set byte writes all ones
// - set bit forces one bit only
// - swap memory nibbles, write back
// - swapped nibbles into accumulator only
`timescale 1ns/1ps

module rss_alu
   import rss_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // decoded instruction
   input wire logic i_valid,
   input wire rss_op_t i_op,
   input wire logic i_use_imm,
   input wire logic [2:0] i_bit_sel,
   // operands
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_mem,
   input wire logic [7:0] i_imm,
   // current flags
   input wire logic i_carry,
   input wire logic i_zero,
   // accumulator write
   output logic o_acc_we,
   output logic [7:0] o_acc,
   // data memory write
   output logic o_mem_we,
   output logic [7:0] o_mem,
   // flag updates
   output logic [5:0] o_flag_we,
   output logic [5:0] o_flags,
   // skip request and dummy cycle to fetch logic
   output logic o_skip,
   output logic o_dummy
);

   // subtract a - b - borrow, returns {ov, ac, c, result}
   function automatic logic [10:0] rss_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic bin);
      logic [8:0] full;
      logic [4:0] low;
      logic [7:0] r;
      logic ov;
      full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      // nibble borrow takes the same borrow-in as the whole byte
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      r = full[7:0];
      ov = (a[RSS_MSB] ^ b[RSS_MSB]) & (a[RSS_MSB] ^ r[RSS_MSB]);
      // a borrow out means negative, so carry reads as not-borrow
      rss_sub = {ov, ~low[RSS_NIB], ~full[RSS_W], r};
   endfunction : rss_sub

   // rotate right one place with a chosen bit entering at the top
   function automatic logic [7:0] rss_ror(input logic [7:0] v, input logic top);
      rss_ror = {top, v[7:1]};
   endfunction : rss_ror

   // exchange the two nibbles of a byte
   function automatic logic [7:0] rss_swap(input logic [7:0] v);
      rss_swap = {v[3:0], v[7:4]};
   endfunction : rss_swap

   // registered state
   // strobes are registered too, so fetch sees them a full cycle
   rss_state_t state_q, state_d;
   logic acc_we_q, acc_we_d;
   logic [7:0] acc_q, acc_d;
   logic mem_we_q, mem_we_d;
   logic [7:0] mem_q, mem_d;
   logic [5:0] flag_we_q, flag_we_d;
   logic [5:0] flags_q, flags_d;
   logic skip_q, skip_d;
   logic dummy_q, dummy_d;

   // combinational helpers
   logic [7:0] sub_b;
   logic [10:0] sub_res;
   logic sub_bin;
   logic is_borrow_op;
   logic [7:0] dec_v;
   logic [7:0] inc_v;
   logic [7:0] bit_mask;
   logic go;

   // subtrahend is memory or immediate; borrow only for the carry forms
   always_comb begin
      sub_b = i_use_imm ? i_imm : i_mem;
      is_borrow_op = (i_op == OP_SUBTRACT_BORROW_TO_ACC) ||
                     (i_op == OP_SUBTRACT_BORROW_TO_MEM);
      sub_bin = is_borrow_op ? ~i_carry : 1'b0;
      sub_res = rss_sub(i_acc, sub_b, sub_bin);
      // eight bit wrap falls out of the width
      dec_v = i_mem - RSS_ONE;
      inc_v = i_mem + RSS_ONE;
      // one-hot mask shared by bit test and bit set
      bit_mask = RSS_ONE << i_bit_sel;
      // an instruction arriving in the dummy cycle is the skipped one
      go = i_valid && (state_q == ST_EXEC);
   end

   // next values of the results, strobes and phase
   always_comb begin
      state_d = ST_EXEC;
      acc_we_d = 1'b0;
      acc_d = acc_q;
      mem_we_d = 1'b0;
      mem_d = mem_q;
      flag_we_d = RSS_FLG_NONE;
      flags_d = flags_q;
      skip_d = 1'b0;
      dummy_d = 1'b0;
      if (state_q == ST_DUMMY) begin
         dummy_d = 1'b0;
      end
      if (go) begin
         unique case (i_op)
            OP_NONE: begin
               acc_we_d = 1'b0;
            end
            // carry goes in at bit 0, old bit 7 becomes carry
            OP_ROTATE_LEFT_THRU_CY_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = {i_mem[6:0], i_carry};
               flag_we_d = RSS_FLG_CARRY;
               flags_d[FLG_C] = i_mem[RSS_MSB];
            end
            OP_ROTATE_RIGHT_MEM: begin
               mem_we_d = 1'b1;
               mem_d = rss_ror(i_mem, i_mem[0]);
            end
            OP_ROTATE_RIGHT_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = rss_ror(i_mem, i_mem[0]);
            end
            // carry goes in at bit 7, old bit 0 becomes carry
            OP_ROTATE_RIGHT_THRU_CARRY: begin
               mem_we_d = 1'b1;
               mem_d = rss_ror(i_mem, i_carry);
               flag_we_d = RSS_FLG_CARRY;
               flags_d[FLG_C] = i_mem[0];
            end
            OP_ROTATE_RIGHT_THRU_CY_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = rss_ror(i_mem, i_carry);
               flag_we_d = RSS_FLG_CARRY;
               flags_d[FLG_C] = i_mem[0];
            end
            // the four subtract forms differ only in borrow and target
            // signed compare is overflow xor sign, the true sign of the difference
            OP_SUBTRACT_BORROW_TO_ACC,
            OP_SUBTRACT_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = sub_res[7:0];
               flag_we_d = RSS_FLG_SUB;
               flags_d[FLG_OV] = sub_res[10];
               flags_d[FLG_AC] = sub_res[9];
               flags_d[FLG_C] = sub_res[8];
               flags_d[FLG_Z] = (sub_res[7:0] == RSS_ZERO);
               flags_d[FLG_SC] = sub_res[10] ^ sub_res[RSS_MSB];
               // chained zero keeps the earlier zero for the borrow form
               flags_d[FLG_CZ] = (sub_res[7:0] == RSS_ZERO) &&
                                 (!is_borrow_op || i_zero);
            end
            OP_SUBTRACT_BORROW_TO_MEM,
            OP_MINUS_TO_MEM: begin
               mem_we_d = 1'b1;
               mem_d = sub_res[7:0];
               flag_we_d = RSS_FLG_SUB;
               flags_d[FLG_OV] = sub_res[10];
               flags_d[FLG_AC] = sub_res[9];
               flags_d[FLG_C] = sub_res[8];
               flags_d[FLG_Z] = (sub_res[7:0] == RSS_ZERO);
               flags_d[FLG_SC] = sub_res[10] ^ sub_res[RSS_MSB];
               flags_d[FLG_CZ] = (sub_res[7:0] == RSS_ZERO) &&
                                 (!is_borrow_op || i_zero);
            end
            // counting skips change no flag
            OP_DEC_SKIP_ZERO: begin
               mem_we_d = 1'b1;
               mem_d = dec_v;
               skip_d = (dec_v == RSS_ZERO);
            end
            OP_DEC_SKIP_ZERO_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = dec_v;
               skip_d = (dec_v == RSS_ZERO);
            end
            OP_INC_SKIP_ZERO: begin
               mem_we_d = 1'b1;
               mem_d = inc_v;
               skip_d = (inc_v == RSS_ZERO);
            end
            OP_INC_SKIP_ZERO_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = inc_v;
               skip_d = (inc_v == RSS_ZERO);
            end
            // byte tests write the operand back unchanged; the bit test writes nothing back
            OP_SKIP_NONZERO: begin
               mem_we_d = 1'b1;
               mem_d = i_mem;
               skip_d = (i_mem != RSS_ZERO);
            end
            OP_SKIP_BIT_NONZERO: begin
               skip_d = |(i_mem & bit_mask);
            end
            OP_SKIP_ZERO: begin
               mem_we_d = 1'b1;
               mem_d = i_mem;
               skip_d = (i_mem == RSS_ZERO);
            end
            OP_SET_BYTE: begin
               mem_we_d = 1'b1;
               mem_d = RSS_ALL_ONES;
            end
            OP_SET_BIT: begin
               mem_we_d = 1'b1;
               mem_d = i_mem | bit_mask;
            end
            OP_NIBBLE_SWAP_MEM: begin
               mem_we_d = 1'b1;
               mem_d = rss_swap(i_mem);
            end
            OP_NIBBLE_EXCHANGE_TO_ACC: begin
               acc_we_d = 1'b1;
               acc_d = rss_swap(i_mem);
            end
            // codes past the last op are illegal on the 5-bit bus; act as no-op
            default: begin
               acc_we_d = 1'b0;
            end
         endcase
         // a taken skip holds the next slot as a dummy cycle
         if (skip_d) begin
            state_d = ST_DUMMY;
         end
      end
      // dummy flag marks the extra cycle of a taken skip
      if (state_d == ST_DUMMY) begin
         dummy_d = 1'b1;
      end
   end

   // registers only; every output comes straight from one of these
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_EXEC;
         acc_we_q <= 1'b0;
         acc_q <= RSS_DATA_RST;
         mem_we_q <= 1'b0;
         mem_q <= RSS_DATA_RST;
         flag_we_q <= RSS_FLG_NONE;
         flags_q <= RSS_FLAG_RST;
         skip_q <= 1'b0;
         dummy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         acc_we_q <= acc_we_d;
         acc_q <= acc_d;
         mem_we_q <= mem_we_d;
         mem_q <= mem_d;
         flag_we_q <= flag_we_d;
         flags_q <= flags_d;
         skip_q <= skip_d;
         dummy_q <= dummy_d;
      end
   end

   // output drive
   // strobes drop on their own, data outputs hold the last write
   assign o_acc_we = acc_we_q;
   assign o_acc = acc_q;
   assign o_mem_we = mem_we_q;
   assign o_mem = mem_q;
   assign o_flag_we = flag_we_q;
   assign o_flags = flags_q;
   assign o_skip = skip_q;
   assign o_dummy = dummy_q;

endmodule : rss_alu

// ===== rss_alu_props.sv
// concurrent checks on the ports of the rotate/subtract/skip datapath
`timescale 1ns/1ps
module rss_alu_props
   import rss_pkg::*;
(
   // clock, reset and decoded instruction
   input wire logic i_mclk, i_rst_n, i_valid, i_use_imm, i_carry, i_zero,
   input wire rss_op_t i_op,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] i_acc, i_mem, i_imm,
   // results
   input wire logic o_acc_we, o_mem_we, o_skip, o_dummy,
   input wire logic [7:0] o_acc, o_mem,
   input wire logic [5:0] o_flag_we, o_flags
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // an instruction taken at this edge
   sequence s_take(rss_op_t o);
      i_valid && i_op == o && !o_dummy;
   endsequence
   property p_rotate_left_thru_cy_to_acc;
      s_take(OP_ROTATE_LEFT_THRU_CY_TO_ACC) |=> o_acc_we && !o_mem_we && o_flag_we == 6'h08
         && o_acc == {$past(i_mem[6:0]), $past(i_carry)} && o_flags[FLG_C] == $past(i_mem[7]);
   endproperty
   a_rotate_left_thru_cy_to_acc: assert property (p_rotate_left_thru_cy_to_acc) else $error("rotate left thru carry wrong");
   property p_rr;
      s_take(OP_ROTATE_RIGHT_MEM) |=> o_mem_we && !o_acc_we && o_flag_we == 6'h00
         && o_mem == {$past(i_mem[0]), $past(i_mem[7:1])};
   endproperty
   a_rr: assert property (p_rr) else $error("rotate right to memory wrong");
   property p_rrc;
      s_take(OP_ROTATE_RIGHT_THRU_CARRY) |=> o_flag_we == 6'h08
         && o_mem == {$past(i_carry), $past(i_mem[7:1])} && o_flags[FLG_C] == $past(i_mem[0]);
   endproperty
   a_rrc: assert property (p_rrc) else $error("rotate right thru carry wrong");
   property p_sub;
      s_take(OP_SUBTRACT_TO_ACC) |=> o_acc_we && o_flag_we == 6'h3F
         && o_acc == $past(i_acc) - $past(i_use_imm ? i_imm : i_mem);
   endproperty
   a_sub: assert property (p_sub) else $error("plain subtract wrong");
   property p_cy;
      (s_take(OP_SUBTRACT_TO_ACC) or s_take(OP_MINUS_TO_MEM))
         |=> o_flags[FLG_C] == ($past(i_acc) >= $past(i_use_imm ? i_imm : i_mem));
   endproperty
   a_cy: assert property (p_cy) else $error("subtract carry wrong");
   // a skip is followed by exactly one empty slot
   property p_dum;
      o_skip |-> o_dummy ##1 (!o_dummy && !o_acc_we && !o_mem_we && !o_skip);
   endproperty
   a_dum: assert property (p_dum) else $error("skip dummy slot wrong");
   property p_dsz;
      s_take(OP_DEC_SKIP_ZERO) |=> o_mem_we && o_flag_we == 6'h00
         && o_mem == $past(i_mem) - 8'h01 && o_skip == ($past(i_mem) == 8'h01);
   endproperty
   a_dsz: assert property (p_dsz) else $error("decrement skip wrong");
   property p_set;
      s_take(OP_SET_BYTE) |=> o_mem_we && o_mem == RSS_ALL_ONES && o_flag_we == 6'h00;
   endproperty
   a_set: assert property (p_set) else $error("set byte wrong");
   property p_swa;
      s_take(OP_NIBBLE_EXCHANGE_TO_ACC) |=> o_acc_we && !o_mem_we
         && o_acc == {$past(i_mem[3:0]), $past(i_mem[7:4])};
   endproperty
   a_swa: assert property (p_swa) else $error("nibble swap to acc wrong");
endmodule : rss_alu_props

// ===== rss_pc_model.sv
// program counter model: steps past taken slots, and once more on a skip
`timescale 1ns/1ps
module rss_pc_model (
   // clock, reset and datapath handshake
   input wire logic i_mclk, i_rst_n, i_valid, i_dummy, i_skip,
   // slot counter
   output logic [7:0] o_pc
);
   logic [7:0] pc_d, pc_q;
   // slot offered during the dummy cycle is lost, not counted
   always_comb begin
      pc_d = pc_q + {7'h00, i_valid && !i_dummy} + {7'h00, i_skip};
   end
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) pc_q <= 8'h00;
      else pc_q <= pc_d;
   end
   assign o_pc = pc_q;
endmodule : rss_pc_model

// ===== rss_pkg.sv
// shared constants and types for the rotate/subtract/skip datapath
package rss_pkg;

   // operand and result width, arithmetic wraps at this width
   localparam int RSS_W = 8;
   localparam int RSS_MSB = 7;
   localparam int RSS_NIB = 4;

   // fixed data patterns
   localparam logic [7:0] RSS_ALL_ONES = 8'hFF;
   localparam logic [7:0] RSS_ZERO = 8'h00;
   localparam logic [7:0] RSS_ONE = 8'h01;

   // status flag positions in the flag vector
   localparam int RSS_NFLAG = 6;
   localparam int FLG_OV = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_AC = 2;
   localparam int FLG_C = 3;
   localparam int FLG_SC = 4;
   localparam int FLG_CZ = 5;

   // flag write masks
   localparam logic [5:0] RSS_FLG_NONE = 6'h00;
   localparam logic [5:0] RSS_FLG_CARRY = 6'h08;
   localparam logic [5:0] RSS_FLG_SUB = 6'h3F;

   // reset values of the result registers
   localparam logic [7:0] RSS_DATA_RST = 8'h00;
   localparam logic [5:0] RSS_FLAG_RST = 6'h00;

   // decoded instruction handed over by the decoder
   typedef enum logic [4:0] {
      OP_NONE,
      OP_ROTATE_LEFT_THRU_CY_TO_ACC,
      OP_ROTATE_RIGHT_MEM,
      OP_ROTATE_RIGHT_TO_ACC,
      OP_ROTATE_RIGHT_THRU_CARRY,
      OP_ROTATE_RIGHT_THRU_CY_TO_ACC,
      OP_SUBTRACT_BORROW_TO_ACC,
      OP_SUBTRACT_BORROW_TO_MEM,
      OP_SUBTRACT_TO_ACC,
      OP_MINUS_TO_MEM,
      OP_DEC_SKIP_ZERO,
      OP_DEC_SKIP_ZERO_TO_ACC,
      OP_INC_SKIP_ZERO,
      OP_INC_SKIP_ZERO_TO_ACC,
      OP_SKIP_NONZERO,
      OP_SKIP_BIT_NONZERO,
      OP_SKIP_ZERO,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_NIBBLE_SWAP_MEM,
      OP_NIBBLE_EXCHANGE_TO_ACC
   } rss_op_t;

   // execution phase: normal or skip dummy cycle
   typedef enum logic {
      ST_EXEC,
      ST_DUMMY
   } rss_state_t;

endpackage : rss_pkg

// ===== tb_top.sv
// self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/1ps
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
   import rss_pkg::*;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, v = 1'b0, ui = 1'b0, cy = 1'b0, z = 1'b0;
   rss_op_t op = OP_NONE;
   logic [2:0] bs = 3'h0;
   logic [7:0] a = 8'h00, m = 8'h00, im = 8'h00, pc, ao, mo;
   logic aw, mw, sk, dm;
   logic [5:0] fw, fl;
   int err_count = 0, checks = 0;
   // 200 MHz core clock
   always #2.5 i_mclk = ~i_mclk;
   rss_alu i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(v), .i_op(op), .i_use_imm(ui),
      .i_bit_sel(bs), .i_acc(a), .i_mem(m), .i_imm(im), .i_carry(cy), .i_zero(z),
      .o_acc_we(aw), .o_acc(ao), .o_mem_we(mw), .o_mem(mo), .o_flag_we(fw), .o_flags(fl),
      .o_skip(sk), .o_dummy(dm));
   rss_pc_model i_pc (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(v), .i_dummy(dm),
      .i_skip(sk), .o_pc(pc));
   // present one instruction just after an edge, leave at the result cycle
   task run(input rss_op_t o, input logic [7:0] ac, input logic [7:0] mm, input logic c);
      @(posedge i_mclk);
      #1;
      op = o;
      a = ac;
      m = mm;
      cy = c;
      v = 1'b1;
      @(posedge i_mclk);
      #1;
      v = 1'b0;
   endtask : run
   // only one destination is written at a time, so one expected value
   task want(input logic ew, input logic emw, input logic [7:0] ev, input logic [5:0] ef,
      input logic es);
      `CK("acc_we", ew, aw)
      `CK("mem_we", emw, mw)
      if (ew) `CK("acc", ev, ao)
      if (emw) `CK("mem", ev, mo)
      `CK("flag_we", ef, fw)
      `CK("skip", es, sk)
      `CK("dummy", es, dm)
   endtask : want
   task t_rot();
      run(OP_ROTATE_LEFT_THRU_CY_TO_ACC, 8'h00, 8'h80, 1'b0);
      want(1'b1, 1'b0, 8'h00, 6'h08, 1'b0);
      `CK("c", 1'b1, fl[FLG_C])
      run(OP_ROTATE_RIGHT_MEM, 8'h00, 8'h01, 1'b1);
      want(1'b0, 1'b1, 8'h80, 6'h00, 1'b0);
      run(OP_ROTATE_RIGHT_TO_ACC, 8'h00, 8'h03, 1'b0);
      want(1'b1, 1'b0, 8'h81, 6'h00, 1'b0);
      run(OP_ROTATE_RIGHT_THRU_CARRY, 8'h00, 8'h01, 1'b1);
      want(1'b0, 1'b1, 8'h80, 6'h08, 1'b0);
      `CK("c", 1'b1, fl[FLG_C])
      run(OP_ROTATE_RIGHT_THRU_CY_TO_ACC, 8'h00, 8'h02, 1'b1);
      want(1'b1, 1'b0, 8'h81, 6'h08, 1'b0);
      `CK("c", 1'b0, fl[FLG_C])
   endtask : t_rot
   // immediate case drives the inverse on memory so a wrong pick shows
   task automatic t_sub();
      logic [8:0] r;
      logic [4:0] l;
      logic b;
      logic ov;
      rss_op_t so [5] = '{OP_SUBTRACT_TO_ACC, OP_MINUS_TO_MEM, OP_SUBTRACT_BORROW_TO_ACC,
         OP_SUBTRACT_BORROW_TO_MEM, OP_SUBTRACT_TO_ACC};
      logic [7:0] av [5] = '{8'h05, 8'h07, 8'h80, 8'h10, 8'h03};
      logic [7:0] mv [5] = '{8'h07, 8'h07, 8'h01, 8'h0F, 8'h03};
      logic cv [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 5; i++) begin
         ui = (i == 4);
         im = mv[i];
         // old zero set only for the borrow form that ends at zero
         z = (i == 3);
         run(so[i], av[i], ui ? ~mv[i] : mv[i], cv[i]);
         b = (i == 2 || i == 3) && !cv[i];
         r = {1'b0, av[i]} - {1'b0, mv[i]} - {8'h00, b};
         l = {1'b0, av[i][3:0]} - {1'b0, mv[i][3:0]} - {4'h0, b};
         ov = av[i][7] != mv[i][7] && r[7] != av[i][7];
         want(i % 2 == 0, i % 2 == 1, r[7:0], 6'h3F, 1'b0);
         `CK("c", !r[8], fl[FLG_C])
         `CK("z", r[7:0] == 8'h00, fl[FLG_Z])
         `CK("ov", ov, fl[FLG_OV])
         `CK("ac", !l[4], fl[FLG_AC])
         `CK("sc", ov ^ r[7], fl[FLG_SC])
         `CK("cz", r[7:0] == 8'h00 && (!(i == 2 || i == 3) || z), fl[FLG_CZ])
      end
      ui = 1'b0;
      z = 1'b0;
   endtask : t_sub
   task t_skip();
      logic [7:0] p0;
      p0 = pc;
      // valid stays high into the dummy slot, and that offer must be dropped
      @(posedge i_mclk);
      #1;
      op = OP_DEC_SKIP_ZERO;
      a = 8'h00;
      m = 8'h01;
      cy = 1'b0;
      v = 1'b1;
      @(posedge i_mclk);
      #1;
      op = OP_SET_BYTE;
      want(1'b0, 1'b1, 8'h00, 6'h00, 1'b1);
      @(posedge i_mclk);
      #1;
      v = 1'b0;
      `CK("dropped", 1'b0, mw)
      run(OP_DEC_SKIP_ZERO, 8'h00, 8'h05, 1'b0);
      want(1'b0, 1'b1, 8'h04, 6'h00, 1'b0);
      run(OP_DEC_SKIP_ZERO_TO_ACC, 8'h00, 8'h01, 1'b0);
      want(1'b1, 1'b0, 8'h00, 6'h00, 1'b1);
      run(OP_DEC_SKIP_ZERO_TO_ACC, 8'h00, 8'h00, 1'b0);
      want(1'b1, 1'b0, 8'hFF, 6'h00, 1'b0);
      run(OP_INC_SKIP_ZERO, 8'h00, 8'hFF, 1'b0);
      want(1'b0, 1'b1, 8'h00, 6'h00, 1'b1);
      run(OP_INC_SKIP_ZERO_TO_ACC, 8'h00, 8'h7F, 1'b0);
      want(1'b1, 1'b0, 8'h80, 6'h00, 1'b0);
      run(OP_INC_SKIP_ZERO_TO_ACC, 8'h00, 8'hFF, 1'b0);
      want(1'b1, 1'b0, 8'h00, 6'h00, 1'b1);
      run(OP_SKIP_NONZERO, 8'h00, 8'h00, 1'b0);
      want(1'b0, 1'b1, 8'h00, 6'h00, 1'b0);
      run(OP_SKIP_NONZERO, 8'h00, 8'h40, 1'b0);
      want(1'b0, 1'b1, 8'h40, 6'h00, 1'b1);
      run(OP_SKIP_ZERO, 8'h00, 8'h00, 1'b0);
      want(1'b0, 1'b1, 8'h00, 6'h00, 1'b1);
      bs = 3'h5;
      run(OP_SKIP_BIT_NONZERO, 8'h00, 8'h20, 1'b0);
      want(1'b0, 1'b0, 8'h00, 6'h00, 1'b1);
      run(OP_SKIP_BIT_NONZERO, 8'h00, 8'hDF, 1'b0);
      want(1'b0, 1'b0, 8'h00, 6'h00, 1'b0);
      // twelve taken slots plus seven skipped ones
      `CK("pc", p0 + 8'h13, pc)
   endtask : t_skip
   task t_set();
      run(OP_SET_BYTE, 8'h00, 8'h12, 1'b0);
      want(1'b0, 1'b1, 8'hFF, 6'h00, 1'b0);
      for (int b = 0; b < 8; b++) begin
         bs = b[2:0];
         run(OP_SET_BIT, 8'h00, 8'h5A, 1'b1);
         want(1'b0, 1'b1, 8'h5A | (8'h01 << b), 6'h00, 1'b0);
      end
      run(OP_NIBBLE_SWAP_MEM, 8'h00, 8'h3C, 1'b0);
      want(1'b0, 1'b1, 8'hC3, 6'h00, 1'b0);
      run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h00, 8'hA1, 1'b0);
      want(1'b1, 1'b0, 8'h1A, 6'h00, 1'b0);
   endtask : t_set
   task tally_and_finish();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      t_rot();
      t_sub();
      t_skip();
      t_set();
      tally_and_finish();
   end
   // watchdog: the sequence needs under 200 cycles, allow three times that
   initial begin
      #3000;
      err_count++;
      tally_and_finish();
   end
endmodule : tb_top
bind rss_alu rss_alu_props i_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid),
   .i_use_imm(i_use_imm), .i_carry(i_carry), .i_zero(i_zero), .i_op(i_op),
   .i_bit_sel(i_bit_sel), .i_acc(i_acc), .i_mem(i_mem), .i_imm(i_imm), .o_acc_we(o_acc_we),
   .o_mem_we(o_mem_we), .o_skip(o_skip), .o_dummy(o_dummy), .o_acc(o_acc), .o_mem(o_mem),
   .o_flag_we(o_flag_we), .o_flags(o_flags));
